// ==== twe_cfg.svh ====
// Constants for the two-wire memory target: prefixes, fields, reset values, timing
`ifndef TWE_CFG_SVH
`define TWE_CFG_SVH
`define TWE_MEM_WORDS 8192
`define TWE_ADDR_W 13
`define TWE_PAGE_W 5
`define TWE_HI_W 5
`define TWE_PREFIX_MEM 4'ha
`define TWE_PREFIX_CFG 4'hb
`define TWE_CFG_SEL 2'h3
`define TWE_CFG_FACTORY 8'h00
`define TWE_CFG_ADDR_HI 7
`define TWE_CFG_ADDR_LO 5
`define TWE_CFG_WP_BIT 1
`define TWE_BIT_LAST 4'h7
`define TWE_BITS_BYTE 4'h8
`define TWE_IDX_DEV 2'h0
`define TWE_IDX_HI 2'h1
`define TWE_IDX_LO 2'h2
`define TWE_IDX_DATA 2'h3
`define TWE_CLK_NS 10
`define TWE_T_WR_NS 4000000
`define TWE_WR_CNT_W 19
`define TWE_FIFO_DEPTH 16
`define TWE_DEV_PFX_HI 7
`define TWE_DEV_PFX_LO 4
`define TWE_DEV_SEL_HI 3
`define TWE_DEV_SEL_LO 1
`define TWE_DEV_RW_BIT 0
`define TWE_WORD_SEL_HI 2
`define TWE_WORD_SEL_LO 1
`define TWE_LINE_IDLE 3'h7
`endif

// ==== twe_pkg.sv ====
// Types shared by the two-wire memory target
package twe_pkg;
    // Bit engine states, Gray coded along load, idle, receive, ack, send, host ack
    typedef enum logic [2:0] {
        TWE_LOAD = 3'h4,
        TWE_IDLE = 3'h0,
        TWE_RX   = 3'h1,
        TWE_ACK  = 3'h3,
        TWE_TX   = 3'h2,
        TWE_RACK = 3'h6
    } twe_state_t;
    // Area selected by the target-address prefix
    typedef enum logic {
        TWE_AREA_MEM = 1'b0,
        TWE_AREA_CFG = 1'b1
    } twe_area_t;
endpackage

// ==== twe_eeprom.sv ====
// Two-wire serial memory target with configuration byte and write buffer
//
// Functional notes
// - 8192 bytes, 13-bit address, 32-byte pages
// - Data changes only while clock low
// - Falling data, clock high: start
// - Rising data, clock high: stop, standby
// - Eight-bit words, ninth clock acknowledges
// - Standby at power-up and after stop
// - Configuration loaded from storage at power-on
// - Three stored address bits, factory 000
// - Stored write-protect bit, factory 0
// - Prefix 1010 array, 1011 configuration
// - Address bits 3..1 must match configuration
// - Bit 0 one reads, zero writes
// - Configuration needs word bits 2,1 set
// - Address bits 7..5, protect bit 1
// - Self-timed write cycle after write
// - Page writes up to 32, wrap
// - Protect bit blocks all array writes
// - Sample on rising, change on falling
// - Data line pulled low or released
// - Answer only the current configured address
// - Protected array data writes get no acknowledge
`timescale 1ns/1ps
`include "twe_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Write buffer between the bus engine and the array
module twe_fifo #(
    parameter int W = 21,
    parameter int D = 16
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic [W-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [W-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(D);
    logic [W-1:0] store [D];        // Entry storage
    logic [AW:0] wr_ptr;            // Write pointer with wrap bit
    logic [AW:0] rd_ptr;            // Read pointer with wrap bit
    logic [AW:0] next_wr_ptr;
    logic [AW:0] next_rd_ptr;
    logic push;
    logic pop;

    // Full and empty from pointer comparison
    assign in_ready_out = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
    assign out_valid_out = (wr_ptr != rd_ptr);
    assign out_data_out = store[rd_ptr[AW-1:0]];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Pointer advance
    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    // Pointer registers
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Entry write, no reset needed on storage
    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            store[wr_ptr[AW-1:0]] <= in_data_in;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Target engine: line sampling, byte framing, decode, array and timer
module twe_eeprom #(
    parameter int unsigned WR_CYCLES = `TWE_T_WR_NS / `TWE_CLK_NS
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    output twe_pkg::twe_state_t state_out,
    output logic standby_out,
    output logic write_busy_out,
    output logic [2:0] configurable_target_address_out,
    output logic array_write_protect_bit_out
);
    import twe_pkg::*;
    localparam int FW = `TWE_ADDR_W + 8;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic scl_m, scl_s, scl_p;       // Clock synchroniser and previous value
    logic sda_m, sda_s, sda_p;       // Data synchroniser and previous value
    logic scl_rise, scl_fall, start_c, stop_c;
    twe_state_t state, next_state;   // Bit engine state
    logic [3:0] bit_cnt, next_bit_cnt;       // Bits in current byte
    logic [7:0] shreg, next_shreg;           // Receive shifter
    logic [7:0] txreg, next_txreg;           // Transmit shifter
    logic [1:0] byte_idx, next_byte_idx;     // Byte position in sequence
    twe_area_t area, next_area;              // Selected area
    logic rd_dir, next_rd_dir;               // Direction of this access
    logic cfg_sel, next_cfg_sel;             // Word bits select configuration
    logic cfg_done, next_cfg_done;           // One configuration byte taken
    logic host_ack, next_host_ack;           // Controller acked a read byte
    logic drive_low, next_drive_low;         // Pull data line low
    logic wrote, next_wrote;                 // Sequence stored data
    logic [`TWE_ADDR_W-1:0] addr, next_addr; // Word address counter
    logic [7:0] cfg_nv, next_cfg_nv;         // Stored configuration byte
    logic [7:0] cfg_pend, next_cfg_pend;     // Configuration byte awaiting commit
    logic cfg_pend_v, next_cfg_pend_v;
    logic [2:0] cfg_addr, next_cfg_addr;     // Live target address
    logic wp, next_wp;                       // Live write protect
    logic [`TWE_WR_CNT_W-1:0] wr_cnt, next_wr_cnt; // Self-timed write counter
    logic [7:0] mem [`TWE_MEM_WORDS];        // Array
    logic [FW-1:0] fifo_in, fifo_out;
    logic fifo_push, fifo_ready, fifo_valid, fifo_pop;
    logic busy, ack_ok;
    logic [3:0] dev_prefix;                  // Area prefix of the received byte
    logic [2:0] dev_sel;                     // Address select bits of the received byte

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage sampling of both lines, third stage for edge finding
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {scl_m, scl_s, scl_p} <= `TWE_LINE_IDLE;
            {sda_m, sda_s, sda_p} <= `TWE_LINE_IDLE;
        end else begin
            {scl_m, scl_s, scl_p} <= {scl_in, scl_m, scl_s};
            {sda_m, sda_s, sda_p} <= {sda_in, sda_m, sda_s};
        end
    end

    assign scl_rise = scl_s && !scl_p;
    assign scl_fall = !scl_s && scl_p;
    assign start_c = scl_s && scl_p && sda_p && !sda_s;
    assign stop_c = scl_s && scl_p && !sda_p && sda_s;
    assign busy = (wr_cnt != '0);
    assign dev_prefix = shreg[`TWE_DEV_PFX_HI:`TWE_DEV_PFX_LO];
    assign dev_sel = shreg[`TWE_DEV_SEL_HI:`TWE_DEV_SEL_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Write buffer; array drains it except while a read byte is being sent
    assign fifo_in = {addr, shreg};
    assign fifo_pop = fifo_valid && (state != TWE_TX);
    twe_fifo #(.W(FW), .D(`TWE_FIFO_DEPTH)) twe_fifo_i (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .in_data_in(fifo_in),
        .in_valid_in(fifo_push),
        .in_ready_out(fifo_ready),
        .out_data_out(fifo_out),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_pop)
    );

    // Array programming from the buffer
    always_ff @(posedge sys_clk_in) begin
        if (fifo_pop) begin
            mem[fifo_out[FW-1:8]] <= fifo_out[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acknowledge decision for the byte just received
    always_comb begin
        ack_ok = 1'b0;
        unique case (byte_idx)
            `TWE_IDX_DEV: begin
                // Prefix, configured address and idle array decide
                ack_ok = !busy && (dev_sel == cfg_addr)
                    && ((dev_prefix == `TWE_PREFIX_MEM)
                    || (dev_prefix == `TWE_PREFIX_CFG));
            end
            `TWE_IDX_HI, `TWE_IDX_LO: begin
                ack_ok = 1'b1;
            end
            `TWE_IDX_DATA: begin
                if (area == TWE_AREA_MEM) begin
                    // Only a write sequence ever takes array data
                    ack_ok = !rd_dir && !wp && fifo_ready;
                end else begin
                    ack_ok = cfg_sel && !cfg_done;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic of the bus engine
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_txreg = txreg;
        next_byte_idx = byte_idx;
        next_area = area;
        next_rd_dir = rd_dir;
        next_cfg_sel = cfg_sel;
        next_cfg_done = cfg_done;
        next_host_ack = host_ack;
        next_drive_low = drive_low;
        next_wrote = wrote;
        next_addr = addr;
        next_cfg_nv = cfg_nv;
        next_cfg_pend = cfg_pend;
        next_cfg_pend_v = cfg_pend_v;
        next_cfg_addr = cfg_addr;
        next_wp = wp;
        next_wr_cnt = busy ? wr_cnt - 1'b1 : wr_cnt;
        fifo_push = 1'b0;
        // End of self-timed cycle makes the new configuration live
        if (wr_cnt == `TWE_WR_CNT_W'(1) && cfg_pend_v) begin
            next_cfg_nv = cfg_pend;
            next_cfg_addr = cfg_pend[`TWE_CFG_ADDR_HI:`TWE_CFG_ADDR_LO];
            next_wp = cfg_pend[`TWE_CFG_WP_BIT];
            next_cfg_pend_v = 1'b0;
        end
        if (state == TWE_LOAD) begin
            // Power-on load of stored configuration before any answer
            next_cfg_addr = cfg_nv[`TWE_CFG_ADDR_HI:`TWE_CFG_ADDR_LO];
            next_wp = cfg_nv[`TWE_CFG_WP_BIT];
            next_state = TWE_IDLE;
        end else if (start_c) begin
            // Start, also repeated start, begins a new address byte
            next_state = TWE_RX;
            next_bit_cnt = '0;
            next_byte_idx = `TWE_IDX_DEV;
            next_cfg_done = 1'b0;
            next_drive_low = 1'b0;
        end else if (stop_c) begin
            // Stop releases the line; a stored write starts the timed cycle
            next_state = TWE_IDLE;
            next_drive_low = 1'b0;
            next_wrote = 1'b0;
            if (wrote) begin
                next_wr_cnt = `TWE_WR_CNT_W'(WR_CYCLES);
            end
        end else begin
            unique case (state)
                TWE_IDLE: begin
                    next_drive_low = 1'b0;
                end
                TWE_RX: begin
                    if (scl_rise && bit_cnt != `TWE_BITS_BYTE) begin
                        next_shreg = {shreg[6:0], sda_s};
                        next_bit_cnt = bit_cnt + 1'b1;
                    end else if (scl_fall && bit_cnt == `TWE_BITS_BYTE) begin
                        next_bit_cnt = '0;
                        if (ack_ok) begin
                            next_state = TWE_ACK;
                            next_drive_low = 1'b1;
                        end else begin
                            next_state = TWE_IDLE;
                        end
                    end
                end
                TWE_ACK: begin
                    if (scl_fall) begin
                        next_drive_low = 1'b0;
                        next_state = TWE_RX;
                        unique case (byte_idx)
                            `TWE_IDX_DEV: begin
                                next_area = (dev_prefix == `TWE_PREFIX_CFG)
                                    ? TWE_AREA_CFG : TWE_AREA_MEM;
                                next_rd_dir = shreg[`TWE_DEV_RW_BIT];
                                next_byte_idx = `TWE_IDX_HI;
                                if (shreg[`TWE_DEV_RW_BIT]) begin
                                    next_byte_idx = `TWE_IDX_DATA;
                                    next_state = TWE_TX;
                                    next_txreg = (dev_prefix == `TWE_PREFIX_CFG)
                                        ? cfg_nv : mem[addr];
                                    next_drive_low = (dev_prefix == `TWE_PREFIX_CFG)
                                        ? !cfg_nv[7] : !mem[addr][7];
                                end
                            end
                            `TWE_IDX_HI: begin
                                next_byte_idx = `TWE_IDX_LO;
                                if (area == TWE_AREA_MEM) begin
                                    next_addr = {shreg[`TWE_HI_W-1:0], addr[7:0]};
                                end else begin
                                    next_cfg_sel = (shreg[`TWE_WORD_SEL_HI:`TWE_WORD_SEL_LO]
                                        == `TWE_CFG_SEL);
                                end
                            end
                            `TWE_IDX_LO: begin
                                next_byte_idx = `TWE_IDX_DATA;
                                if (area == TWE_AREA_MEM) begin
                                    next_addr = {addr[`TWE_ADDR_W-1:8], shreg};
                                end
                            end
                            `TWE_IDX_DATA: begin
                                next_wrote = 1'b1;
                                if (area == TWE_AREA_MEM) begin
                                    fifo_push = 1'b1;
                                    // Low bits wrap inside the page
                                    next_addr[`TWE_PAGE_W-1:0] =
                                        addr[`TWE_PAGE_W-1:0] + 1'b1;
                                end else begin
                                    // Address field kept while protection is on
                                    next_cfg_pend = {wp ? cfg_addr
                                        : shreg[`TWE_CFG_ADDR_HI:`TWE_CFG_ADDR_LO],
                                        3'h0, shreg[`TWE_CFG_WP_BIT], 1'b0};
                                    next_cfg_pend_v = 1'b1;
                                    next_cfg_done = 1'b1;
                                end
                            end
                        endcase
                    end
                end
                TWE_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == `TWE_BIT_LAST) begin
                            next_state = TWE_RACK;
                            next_drive_low = 1'b0;
                            next_bit_cnt = '0;
                            if (area == TWE_AREA_MEM) begin
                                next_addr = addr + 1'b1;  // whole-array wrap on read
                            end
                        end else begin
                            next_txreg = {txreg[6:0], 1'b0};
                            next_drive_low = !txreg[6];
                            next_bit_cnt = bit_cnt + 1'b1;
                        end
                    end
                end
                TWE_RACK: begin
                    if (scl_rise) begin
                        next_host_ack = !sda_s;
                    end else if (scl_fall) begin
                        if (host_ack && area == TWE_AREA_MEM) begin
                            next_state = TWE_TX;
                            next_txreg = mem[addr];
                            next_drive_low = !mem[addr][7];
                        end else begin
                            next_state = TWE_IDLE;
                        end
                    end
                end
                default: begin
                    next_state = TWE_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Engine registers; stored configuration starts at factory value
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= TWE_LOAD;
            bit_cnt <= '0;
            shreg <= '0;
            txreg <= '0;
            byte_idx <= `TWE_IDX_DEV;
            area <= TWE_AREA_MEM;
            rd_dir <= 1'b0;
            cfg_sel <= 1'b0;
            cfg_done <= 1'b0;
            host_ack <= 1'b0;
            drive_low <= 1'b0;
            wrote <= 1'b0;
            addr <= '0;
            cfg_nv <= `TWE_CFG_FACTORY;
            cfg_pend <= `TWE_CFG_FACTORY;
            cfg_pend_v <= 1'b0;
            cfg_addr <= '0;
            wp <= 1'b0;
            wr_cnt <= '0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            txreg <= next_txreg;
            byte_idx <= next_byte_idx;
            area <= next_area;
            rd_dir <= next_rd_dir;
            cfg_sel <= next_cfg_sel;
            cfg_done <= next_cfg_done;
            host_ack <= next_host_ack;
            drive_low <= next_drive_low;
            wrote <= next_wrote;
            addr <= next_addr;
            cfg_nv <= next_cfg_nv;
            cfg_pend <= next_cfg_pend;
            cfg_pend_v <= next_cfg_pend_v;
            cfg_addr <= next_cfg_addr;
            wp <= next_wp;
            wr_cnt <= next_wr_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs: line only ever pulled low or released
    assign sda_out = 1'b0;
    assign sda_oe_n_out = !drive_low;
    assign state_out = state;
    assign standby_out = (state == TWE_IDLE) && !busy;
    assign write_busy_out = busy;
    assign configurable_target_address_out = cfg_addr;
    assign array_write_protect_bit_out = wp;
endmodule

// ==== twe_eeprom_sva.sv ====
// Port checker for the two-wire memory target
`timescale 1ns/1ps
module twe_eeprom_sva #(parameter int unsigned WR_CYCLES = 50) (
    input logic sys_clk_in,
    input logic resetn_in,
    input logic scl_in,
    input logic sda_in,
    input logic sda_out,
    input logic sda_oe_n_out,
    input twe_pkg::twe_state_t state_out,
    input logic standby_out,
    input logic write_busy_out,
    input logic [2:0] configurable_target_address_out,
    input logic array_write_protect_bit_out
);
    import twe_pkg::*;
    int unsigned busy_cnt, next_busy_cnt; // Length of the running timed write
    // Count busy cycles, clear when idle
    always_comb next_busy_cnt = write_busy_out ? busy_cnt + 1 : 0;
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) busy_cnt <= 0;
        else busy_cnt <= next_busy_cnt;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_start; scl_in && $fell(sda_in); endsequence
    sequence s_stop; scl_in && $rose(sda_in); endsequence
    ////////////////////////////////////////////////////////////
    a_pull_only: assert property (!sda_oe_n_out |-> !sda_out)
        else $error("data line driven high");
    a_drive_scl_low: assert property ($changed(sda_oe_n_out) |-> !scl_in)
        else $error("data changed with clock high");
    a_busy_no_sleep: assert property (write_busy_out |-> !standby_out)
        else $error("standby during write");
    a_write_time: assert property ($fell(write_busy_out) |->
        busy_cnt + 1 >= WR_CYCLES && busy_cnt <= WR_CYCLES + 1) else $error("write length");
    a_cfg_after_write: assert property (
        $changed({configurable_target_address_out, array_write_protect_bit_out})
        |-> $past(write_busy_out)) else $error("config changed outside write");
    a_load_then_idle: assert property (state_out == TWE_LOAD |=> state_out == TWE_IDLE)
        else $error("load not followed by idle");
    a_start_recv: assert property (
        s_start ##0 (state_out == TWE_IDLE && !write_busy_out) |-> ##[1:6] state_out == TWE_RX)
        else $error("start not taken");
    a_stop_idle: assert property (s_stop |-> ##[1:6] state_out == TWE_IDLE)
        else $error("stop not taken");
    a_ack_stands: assert property ($fell(sda_oe_n_out) |-> !sda_oe_n_out [*8])
        else $error("low bit too short");
endmodule
bind twe_eeprom twe_eeprom_sva #(.WR_CYCLES(WR_CYCLES)) twe_eeprom_sva_i (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .state_out(state_out),
    .standby_out(standby_out), .write_busy_out(write_busy_out),
    .configurable_target_address_out(configurable_target_address_out),
    .array_write_protect_bit_out(array_write_protect_bit_out));

// ==== twe_host.sv ====
// Two-wire bus controller model, open drain on the data line
`timescale 1ns/1ps
module twe_host (
    input wire logic sys_clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    // Idle bus: clock high, data released
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    ////////////////////////////////////////////////////////////
    // Wait falling system clock edges
    task automatic hw(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask
    // Data set well inside clock low, read in mid clock high
    task automatic bit_io(input logic b, output logic s);
        hw(2);
        sda_out = b;
        hw(4);
        scl_out = 1'b1;
        hw(3);
        s = sda_in;
        hw(3);
        scl_out = 1'b0;
    endtask
    // Data edge while clock high
    task automatic cond(input logic first, input logic last);
        hw(2);
        sda_out = first;
        hw(4);
        scl_out = 1'b1;
        hw(4);
        sda_out = last;
        hw(4);
    endtask
    task automatic start();
        cond(1'b1, 1'b0);
        scl_out = 1'b0;
    endtask
    task automatic stop();
        cond(1'b0, 1'b1);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, nack);
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, s);
    endtask
    // Clock until the line is seen high, then start and stop
    task automatic recover();
        logic s;
        for (int i = 0; i < 9; i++) begin
            bit_io(1'b1, s);
            if (s) break;
        end
        start();
        stop();
    endtask
endmodule

// ==== twe_eeprom_tb.sv ====
// Self-checking bench for the two-wire memory target
`timescale 1ns/1ps
module twe_eeprom_tb;
    import twe_pkg::*;
    localparam int WR = 50; // Shortened timed write
    logic sys_clk = 1'b0, resetn = 1'b0, scl, sda_rel, sda_out, sda_oe_n, standby, busy, wp;
    twe_state_t state;
    logic [2:0] cfg;
    int mismatches = 0, check_count = 0, cycles = 0;
    wire sda = sda_rel & (sda_oe_n | sda_out); // Wire-AND with pull-up
    always #5 sys_clk = ~sys_clk;
    twe_host twe_host_i (.sys_clk_in(sys_clk), .sda_in(sda), .scl_out(scl), .sda_out(sda_rel));
    twe_eeprom #(.WR_CYCLES(WR)) twe_eeprom_i (.sys_clk_in(sys_clk), .resetn_in(resetn),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n),
        .state_out(state), .standby_out(standby), .write_busy_out(busy),
        .configurable_target_address_out(cfg), .array_write_protect_bit_out(wp));
    ////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic send(input logic [7:0] b, input logic exp_nack);
        logic n;
        twe_host_i.wr_byte(b, n);
        chk(8'(n), 8'(exp_nack));
    endtask
    // Start, target byte, both word address bytes
    task automatic hdr(input logic [7:0] dev, input logic [12:0] a);
        twe_host_i.start();
        send(dev, 1'b0);
        send({3'h0, a[12:8]}, 1'b0);
        send(a[7:0], 1'b0);
    endtask
    // Write n counting bytes, stop, wait out the timed write
    task automatic wr(input logic [7:0] dev, input logic [12:0] a, input logic [7:0] d0,
        input int n, input logic dn);
        hdr(dev, a);
        for (int i = 0; i < n; i++) send(8'(d0 + i), dn);
        twe_host_i.stop();
        twe_host_i.hw(4);
        chk(8'(busy), 8'(!dn));
        for (int i = 0; i < WR + 20 && standby !== 1'b1; i++) twe_host_i.hw(1);
        chk(8'(standby), 8'h01);
    endtask
    // Dummy write, repeated start, n sequential bytes
    task automatic rd(input logic [7:0] dev, input logic [12:0] a, input int n,
        input logic [7:0] e0);
        logic [7:0] d;
        hdr(dev, a);
        twe_host_i.start();
        send(dev | 8'h01, 1'b0);
        for (int i = 0; i < n; i++) begin
            twe_host_i.rd_byte(i == n - 1, d);
            chk(d, 8'(e0 + i));
        end
        twe_host_i.stop();
        twe_host_i.hw(4);
        chk(8'(standby), 8'h01);
    endtask
    task automatic probe(input logic [7:0] dev);
        twe_host_i.start();
        send(dev, 1'b1);
        twe_host_i.stop();
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        twe_host_i.hw(4);
        chk(8'(state), 8'(TWE_LOAD));
        resetn = 1'b1;
        twe_host_i.hw(4);
        chk(8'(standby), 8'h01);
        chk(8'(cfg), 8'h00);
        chk(8'(wp), 8'h00);
        $display("test reset done");
        wr(8'ha0, 13'h1fe2, 8'ha5, 1, 1'b0);
        rd(8'ha0, 13'h1fe2, 1, 8'ha5);
        wr(8'ha0, 13'h005e, 8'h31, 4, 1'b0);
        rd(8'ha0, 13'h005e, 2, 8'h31);
        rd(8'ha0, 13'h0040, 1, 8'h33);
        twe_host_i.start();
        send(8'ha1, 1'b0);
        twe_host_i.recover();
        chk(8'(state), 8'(TWE_IDLE));
        $display("test array done");
        probe(8'hc0);
        probe(8'hb2);
        wr(8'hb0, 13'h0600, 8'h42, 1, 1'b0);
        chk(8'(cfg), 8'h02);
        chk(8'(wp), 8'h01);
        probe(8'ha0);
        wr(8'ha4, 13'h1fe2, 8'h00, 1, 1'b1);
        rd(8'ha4, 13'h1fe2, 1, 8'ha5);
        rd(8'hb4, 13'h0600, 1, 8'h42);
        wr(8'hb4, 13'h0000, 8'h00, 1, 1'b1);
        wr(8'hb4, 13'h0600, 8'he0, 1, 1'b0);
        chk(8'(cfg), 8'h02); // protected address bits kept
        chk(8'(wp), 8'h00);
        $display("test config done");
        close_out();
    end
endmodule
